// file: core/imu_cal_ctrl.v
// calibration, command, sample timing, sleep and filter logic of the inertial module
// assumes raw sensor codes and the aux conversion come from logic on mclk;
// the serial pins come from the host and are synchronised here
`timescale 1ns/10ps
`include "imu_consts.vh"

module imu_cal_ctrl #(
  parameter [31:0] P_TB_SHORT_CYC = `IMU_TB_SHORT_NS / `IMU_CLK_PERIOD_NS,
  parameter [31:0] P_TB_LONG_CYC  = `IMU_TB_LONG_NS / `IMU_CLK_PERIOD_NS,
  parameter [31:0] P_SLEEP_CYC    = `IMU_SLEEP_STEP_MS * `IMU_CLK_KHZ,
  parameter [31:0] P_FLASH_CYC    = `IMU_FLASH_MS * `IMU_CLK_KHZ,
  parameter [31:0] P_PREC_CYC     = `IMU_PREC_MS * `IMU_CLK_KHZ,
  parameter [15:0] P_PRODUCT_ID   = 16'h5A5A  // arbitrary value
) (
  input  wire        mclk,          // 125 MHz clock
  input  wire        rstn,          // async reset, active low
  input  wire        spi_sclk,      // serial clock, idles high
  input  wire        spi_cs_n,      // chip select, active low
  input  wire        spi_din,       // serial data in
  output reg         spi_dout,      // serial data out
  output reg         spi_dout_oe,   // dout driven while selected
  input  wire [13:0] gyro_x_raw,    // raw gyro x
  input  wire [13:0] gyro_y_raw,    // raw gyro y
  input  wire [13:0] gyro_z_raw,    // raw gyro z
  input  wire [13:0] accel_x_raw,   // raw accel x
  input  wire [13:0] accel_y_raw,   // raw accel y
  input  wire [13:0] accel_z_raw,   // raw accel z
  input  wire [13:0] mag_x_raw,     // raw mag x
  input  wire [13:0] mag_y_raw,     // raw mag y
  input  wire [13:0] mag_z_raw,     // raw mag z
  input  wire [11:0] aux_adc_code,  // aux conversion result
  output reg  [11:0] dac_data,      // DAC input register
  output reg         low_power,     // low power mode
  output reg         sleeping,      // sleep in progress
  output reg         flash_busy,    // flash commit in progress
  output reg         offline,       // precision null collecting
  output reg         sample_tick    // one pulse per internal sample
);

  localparam [3:0] ST_RUN   = 4'b0001;
  localparam [3:0] ST_PREC  = 4'b0010;
  localparam [3:0] ST_FLASH = 4'b0100;
  localparam [3:0] ST_SLEEP = 4'b1000;

  wire [125:0] raw_v = {mag_z_raw, mag_y_raw, mag_x_raw, accel_z_raw, accel_y_raw,
                        accel_x_raw, gyro_z_raw, gyro_y_raw, gyro_x_raw};

  reg  [15:0] cal [0:11];
  reg  [15:0] sh_cal [0:11];
  reg  [15:0] misc_ctrl, sample_period_control, filter_and_range_control, aux_dac;
  reg  [15:0] sh_misc, sh_smpl, sh_filt;
  reg  [13:0] h1 [0:143];
  reg  [13:0] h2 [0:143];
  reg  [125:0] out_v;
  reg  [11:0] aux_reg;
  reg         nd;
  reg  [3:0]  state;
  reg  [31:0] op_cnt;
  reg  [7:0]  slp_left;
  reg         slp_inf;
  reg         clr_req;
  reg  signed [17:0] ema [0:2];
  reg  [31:0] tb_cnt;
  reg  [6:0]  inc_cnt;
  integer     i, k;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  function [15:0] satw;
    input signed [19:0] v;
    input [4:0]         w;
    reg signed [19:0]   lim;
    begin
      lim = 20'sd1 <<< (w - 5'd1);
      if (v > lim - 20'sd1)
        satw = lim[15:0] - 16'h0001;
      else if (v < -lim)
        satw = -lim[15:0];
      else
        satw = v[15:0];
    end
  endfunction

  function signed [17:0] sx14;
    input [13:0] v;
    begin
      sx14 = $signed({{4{v[13]}}, v});
    end
  endfunction

  function [13:0] corr_val;
    input [3:0] ch;
    reg signed [17:0] s;
    reg signed [30:0] p;
    reg [15:0]        b;
    reg [15:0]        t;
    begin
      b = cal[ch];
      s = sx14(raw_v[ch*14 +: 14]);
      p = 31'sd0;
      if (ch < 4'd3) begin
        s = s + ($signed({{5{b[12]}}, b[12:0]}) >>> 2);
        if (misc_ctrl[`IMU_MISC_LINCOMP])
          s = s - (sx14(raw_v[(ch+4'd3)*14 +: 14]) >>> `IMU_GLIN_SHIFT);
      end else if (ch < 4'd6) begin
        s = s + $signed({{6{b[11]}}, b[11:0]});
      end else begin
        s = s + $signed({{4{b[13]}}, b[13:0]});
        p = s * $signed({1'b0, cal[ch+4'd3][11:0]});
        p = p >>> `IMU_SIF_SHIFT;
        s = p[17:0];
      end
      t = satw({{2{s[17]}}, s}, 5'd14);
      corr_val = t[13:0];
    end
  endfunction

  function [15:0] cal_mask;
    input [3:0] idx;
    begin
      if (idx < 4'd3)
        cal_mask = `IMU_M_GYRO;
      else if (idx < 4'd6)
        cal_mask = `IMU_M_ACCL;
      else if (idx < 4'd9)
        cal_mask = `IMU_M_HIF;
      else
        cal_mask = `IMU_M_SIF;
    end
  endfunction

  function [15:0] bmerge;
    input [15:0] old;
    input        hi;
    input [7:0]  d;
    input [15:0] m;
    begin
      bmerge = (hi ? {d, old[7:0]} : {old[15:8], d}) & m;
    end
  endfunction

  function [15:0] reg_read;
    input [6:0] a;
    reg [6:0]   aw;
    reg [6:0]   off;
    begin
      aw = {a[6:1], 1'b0};
      reg_read = 16'h0000;
      if (aw >= `IMU_A_OUT_FIRST && aw <= `IMU_A_OUT_LAST) begin
        off = aw - `IMU_A_OUT_FIRST;
        reg_read = {nd, 1'b0, out_v[off[4:1]*14 +: 14]};
      end else if (aw >= `IMU_A_CAL_FIRST && aw <= `IMU_A_CAL_LAST) begin
        off = aw - `IMU_A_CAL_FIRST;
        reg_read = cal[off[4:1]];
      end else begin
        case (aw)
          `IMU_A_AUX_ADC: reg_read = {4'h0, aux_reg};
          `IMU_A_MISC:    reg_read = misc_ctrl;
          `IMU_A_SMPL:    reg_read = sample_period_control;
          `IMU_A_FILT:    reg_read = filter_and_range_control;
          `IMU_A_DAC:     reg_read = aux_dac;
          `IMU_A_PROD:    reg_read = P_PRODUCT_ID;
          default:        reg_read = 16'h0000;
        endcase
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // serial port
  // ----------------------------------------------------------------
  reg        sclk_s1, sclk_s2, sclk_s3, cs_s1, cs_s2, cs_s3, din_s1, din_s2;
  reg [3:0]  bit_cnt;
  reg [14:0] rx;
  reg [15:0] shreg, frame_word;
  reg        frame_done, burst;
  reg [3:0]  burst_idx;
  reg [6:0]  resp_addr;
  wire       sclk_rise = sclk_s2 & ~sclk_s3;
  wire       sclk_fall = ~sclk_s2 & sclk_s3;
  wire       cs_fall   = ~cs_s2 & cs_s3;
  wire [15:0] word_in  = {rx, din_s2};
  wire [15:0] resp     = reg_read(burst ? {burst_idx, 1'b0} + `IMU_A_SUPPLY : resp_addr);

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      {sclk_s1, sclk_s2, sclk_s3, cs_s1, cs_s2, cs_s3} <= 6'h3F;
      {din_s1, din_s2} <= 2'h0;
      bit_cnt     <= 4'h0;
      rx          <= 15'h0000;
      shreg       <= 16'h0000;
      frame_word  <= 16'h0000;
      frame_done  <= 1'b0;
      burst       <= 1'b0;
      burst_idx   <= 4'h0;
      resp_addr   <= 7'h00;
      spi_dout    <= 1'b0;
      spi_dout_oe <= 1'b0;
    end else begin
      {sclk_s3, sclk_s2, sclk_s1} <= {sclk_s2, sclk_s1, spi_sclk};
      {cs_s3, cs_s2, cs_s1}       <= {cs_s2, cs_s1, spi_cs_n};
      {din_s2, din_s1}            <= {din_s1, spi_din};
      frame_done  <= 1'b0;
      spi_dout_oe <= ~cs_s2;
      if (cs_s2) begin
        bit_cnt <= 4'h0;
        burst   <= 1'b0;
      end else begin
        if (sclk_fall) begin
          if (bit_cnt == 4'h0) begin
            shreg    <= resp;
            spi_dout <= resp[15];
          end else
            spi_dout <= shreg[~bit_cnt];
        end
        if (sclk_rise) begin
          rx      <= word_in[14:0];
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == 4'hF) begin
            frame_done <= 1'b1;
            frame_word <= word_in;
            if (burst)
              burst_idx <= (burst_idx == `IMU_BURST_WORDS - 4'h1) ? 4'h0
                                                                   : burst_idx + 4'h1;
            else if (!word_in[15] && {word_in[14:9], 1'b0} == `IMU_A_GLOB) begin
              burst     <= 1'b1;
              burst_idx <= 4'h0;
            end else if (!word_in[15])
              resp_addr <= word_in[14:8];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // sample period
  // ----------------------------------------------------------------
  // base times increment plus one
  wire [31:0] tb_len = sample_period_control[`IMU_SMPL_BASE] ? P_TB_LONG_CYC : P_TB_SHORT_CYC;

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tb_cnt      <= 32'h00000000;
      inc_cnt     <= 7'h00;
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= 1'b0;
      if (state == ST_SLEEP) begin
        tb_cnt  <= 32'h00000000;
        inc_cnt <= 7'h00;
      end else if (tb_cnt >= tb_len - 32'h1) begin
        tb_cnt <= 32'h00000000;
        if (inc_cnt >= sample_period_control[6:0]) begin
          inc_cnt     <= 7'h00;
          sample_tick <= 1'b1;
        end else
          inc_cnt <= inc_cnt + 7'h01;
      end else
        tb_cnt <= tb_cnt + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // two-stage averaging filter
  // ----------------------------------------------------------------
  // taps per stage from low three bits
  wire [2:0] flog = (filter_and_range_control[2:0] > `IMU_FILT_MAX_LOG) ?
                    `IMU_FILT_MAX_LOG : filter_and_range_control[2:0];
  wire [4:0] taps = 5'h01 << flog;
  reg  [125:0] in_v, avg1_v, avg2_v;
  reg  signed [19:0] acc;

  always @* begin
    acc = 20'sd0;
    for (i = 0; i < 9; i = i + 1) begin
      in_v[i*14 +: 14] = corr_val(i[3:0]);
      acc = $signed({{6{in_v[i*14+13]}}, in_v[i*14 +: 14]});
      for (k = 0; k < 15; k = k + 1)
        if (k < taps - 5'h01)
          acc = acc + $signed({{6{h1[i*16+k][13]}}, h1[i*16+k]});
      acc = acc >>> flog;
      avg1_v[i*14 +: 14] = acc[13:0];
      acc = $signed({{6{acc[13]}}, acc[13:0]});
      for (k = 0; k < 15; k = k + 1)
        if (k < taps - 5'h01)
          acc = acc + $signed({{6{h2[i*16+k][13]}}, h2[i*16+k]});
      acc = acc >>> flog;
      avg2_v[i*14 +: 14] = acc[13:0];
    end
  end

  // ----------------------------------------------------------------
  // registers, commands, sleep and data path
  // ----------------------------------------------------------------
  wire       wr       = frame_done & frame_word[15];
  wire [6:0] wa       = frame_word[14:8];
  wire [7:0] wd       = frame_word[7:0];
  wire [6:0] wa_w     = {wa[6:1], 1'b0};
  wire [6:0] cal_off  = wa_w - `IMU_A_CAL_FIRST;
  wire       in_cal   = (wa_w >= `IMU_A_CAL_FIRST) && (wa_w <= `IMU_A_CAL_LAST);
  wire       glob_wr  = wr && (wa == `IMU_A_GLOB) && (state == ST_RUN);
  wire       slp_wr   = wr && (wa_w == `IMU_A_SLEEP) && (state == ST_RUN);
  wire [15:0] slp_val = bmerge(16'h0000, wa[0], wd, `IMU_M_SLP);

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (i = 0; i < 12; i = i + 1) begin
        cal[i]    <= (i > 8) ? `IMU_RST_SIF : `IMU_RST_ZERO;
        sh_cal[i] <= (i > 8) ? `IMU_RST_SIF : `IMU_RST_ZERO;
      end
      for (i = 0; i < 144; i = i + 1) begin
        h1[i] <= 14'h0000;
        h2[i] <= 14'h0000;
      end
      for (i = 0; i < 3; i = i + 1)
        ema[i] <= 18'sd0;
      misc_ctrl <= `IMU_RST_MISC;
      sh_misc   <= `IMU_RST_MISC;
      sample_period_control <= `IMU_RST_SMPL;
      sh_smpl   <= `IMU_RST_SMPL;
      filter_and_range_control <= `IMU_RST_FILT;
      sh_filt   <= `IMU_RST_FILT;
      aux_dac   <= 16'h0000;
      dac_data  <= 12'h000;
      out_v     <= 126'h0;
      aux_reg   <= 12'h000;
      nd        <= 1'b0;
      state     <= ST_RUN;
      op_cnt    <= 32'h00000000;
      slp_left  <= 8'h00;
      slp_inf   <= 1'b0;
      clr_req   <= 1'b0;
      low_power <= 1'b0;
      sleeping  <= 1'b0;
      flash_busy <= 1'b0;
      offline   <= 1'b0;
    end else begin
      clr_req <= 1'b0;
      low_power  <= sample_period_control[7:0] >= `IMU_LOW_POWER_MIN;
      sleeping   <= (state == ST_SLEEP);
      flash_busy <= (state == ST_FLASH);
      offline    <= (state == ST_PREC);

      if (wr) begin
        if (in_cal)
          cal[cal_off[4:1]] <= bmerge(cal[cal_off[4:1]], wa[0], wd, cal_mask(cal_off[4:1]));
        case (wa_w)
          `IMU_A_MISC: misc_ctrl <= bmerge(misc_ctrl, wa[0], wd, `IMU_M_MISC);
          `IMU_A_SMPL: sample_period_control <=
                         bmerge(sample_period_control, wa[0], wd, `IMU_M_SMPL);
          `IMU_A_FILT: filter_and_range_control <=
                         bmerge(filter_and_range_control, wa[0], wd, `IMU_M_FILT);
          `IMU_A_DAC:  aux_dac <= bmerge(aux_dac, wa[0], wd, `IMU_M_DAC);
          default:     aux_dac <= aux_dac;
        endcase
      end
      if (frame_done && !frame_word[15])
        nd <= 1'b0;

      // each command runs to completion and sleep runs out or ends on a select, then the state returns to run
      case (state)
        ST_RUN: begin
          if (glob_wr) begin
            if (wd[`IMU_CMD_DAC])
              dac_data <= aux_dac[11:0];
            if (wd[`IMU_CMD_SWRESET]) begin
              for (i = 0; i < 12; i = i + 1)
                cal[i] <= sh_cal[i];
              misc_ctrl <= sh_misc;
              sample_period_control <= sh_smpl;
              filter_and_range_control <= sh_filt;
              clr_req <= 1'b1;
            end else if (wd[`IMU_CMD_PREC]) begin
              state  <= ST_PREC;
              op_cnt <= 32'h00000000;
              for (i = 0; i < 3; i = i + 1)
                ema[i] <= 18'sd0;
            end else if (wd[`IMU_CMD_AUTONULL]) begin
              // negate measured gyro outputs into bias
              for (i = 0; i < 3; i = i + 1)
                cal[i] <= satw($signed({{3{cal[i][12]}}, cal[i][12:0]}) -
                               ($signed({{6{out_v[i*14+13]}}, out_v[i*14 +: 14]}) <<< 2),
                               5'd13) & `IMU_M_GYRO;
              clr_req <= 1'b1;
              state   <= ST_FLASH;
              op_cnt  <= 32'h00000000;
            end else if (wd[`IMU_CMD_RESTORE]) begin
              for (i = 0; i < 12; i = i + 1)
                cal[i] <= 16'h0000;
              clr_req <= 1'b1;
              state   <= ST_FLASH;
              op_cnt  <= 32'h00000000;
            end else if (wd[`IMU_CMD_FLASH]) begin
              state  <= ST_FLASH;
              op_cnt <= 32'h00000000;
            end
          end else if (slp_wr && (slp_val[`IMU_SLP_INF] || slp_val[7:0] != 8'h00)) begin
            state    <= ST_SLEEP;
            slp_inf  <= slp_val[`IMU_SLP_INF];
            slp_left <= slp_val[7:0];
            op_cnt   <= 32'h00000000;
          end
        end
        ST_PREC: begin
          if (sample_tick)
            for (i = 0; i < 3; i = i + 1)
              ema[i] <= ema[i] + ((sx14(in_v[i*14 +: 14]) - ema[i]) >>> `IMU_EMA_SHIFT);
          if (op_cnt >= P_PREC_CYC - 32'h1) begin
            for (i = 0; i < 3; i = i + 1)
              cal[i] <= satw($signed({{3{cal[i][12]}}, cal[i][12:0]}) -
                             ($signed({{2{ema[i][17]}}, ema[i]}) <<< 2), 5'd13) & `IMU_M_GYRO;
            clr_req <= 1'b1;
            state   <= ST_FLASH;
            op_cnt  <= 32'h00000000;
          end else
            op_cnt <= op_cnt + 32'h1;
        end
        ST_FLASH: begin
          // commit to flash within the window
          if (op_cnt >= P_FLASH_CYC - 32'h1) begin
            for (i = 0; i < 12; i = i + 1)
              sh_cal[i] <= cal[i];
            sh_misc <= misc_ctrl;
            sh_smpl <= sample_period_control;
            sh_filt <= filter_and_range_control;
            state   <= ST_RUN;
          end else
            op_cnt <= op_cnt + 32'h1;
        end
        ST_SLEEP: begin
          if (cs_fall)
            state <= ST_RUN;
          else if (!slp_inf) begin
            if (op_cnt >= P_SLEEP_CYC - 32'h1) begin
              op_cnt <= 32'h00000000;
              if (slp_left <= 8'h01)
                state <= ST_RUN;
              slp_left <= slp_left - 8'h01;
            end else
              op_cnt <= op_cnt + 32'h1;
          end
        end
        default: state <= ST_RUN;
      endcase

      if (clr_req) begin
        out_v <= 126'h0;
        nd    <= 1'b0;
        for (i = 0; i < 144; i = i + 1) begin
          h1[i] <= 14'h0000;
          h2[i] <= 14'h0000;
        end
      end else if (sample_tick && state != ST_PREC) begin
        for (i = 0; i < 9; i = i + 1) begin
          for (k = 15; k > 0; k = k - 1) begin
            h1[i*16+k] <= h1[i*16+k-1];
            h2[i*16+k] <= h2[i*16+k-1];
          end
          h1[i*16] <= in_v[i*14 +: 14];
          h2[i*16] <= avg1_v[i*14 +: 14];
        end
        out_v   <= avg2_v;
        aux_reg <= aux_adc_code;
        nd      <= 1'b1;
      end
    end
  end

endmodule // imu_cal_ctrl

// file: core/imu_consts.vh
// constants for the calibration and control block: offsets, fields, resets, times
// assumes a 125 MHz mclk and a 16-bit serial frame: rd/wr bit, 7-bit address, data byte
`ifndef IMU_CONSTS_VH
`define IMU_CONSTS_VH

// ----------------------------------------------------------------
// clock and times
// ----------------------------------------------------------------
`define IMU_CLK_PERIOD_NS 8
`define IMU_CLK_KHZ       32'd125000
`define IMU_TB_SHORT_NS   610350
`define IMU_TB_LONG_NS    18921000
`define IMU_SLEEP_STEP_MS 500
`define IMU_FLASH_MS      50
`define IMU_PREC_MS       30000

// ----------------------------------------------------------------
// byte addresses of the low bytes
// ----------------------------------------------------------------
`define IMU_A_SUPPLY    7'h02
`define IMU_A_OUT_FIRST 7'h04
`define IMU_A_OUT_LAST  7'h14
`define IMU_A_TEMP      7'h16
`define IMU_A_AUX_ADC   7'h18
`define IMU_A_CAL_FIRST 7'h1A
`define IMU_A_CAL_LAST  7'h30
`define IMU_A_MISC      7'h34
`define IMU_A_SMPL      7'h36
`define IMU_A_FILT      7'h38
`define IMU_A_SLEEP     7'h3A
`define IMU_A_GLOB      7'h3E
`define IMU_A_DAC       7'h4A
`define IMU_A_PROD      7'h56
`define IMU_BURST_WORDS 4'hC

// ----------------------------------------------------------------
// fields and masks
// ----------------------------------------------------------------
`define IMU_CMD_AUTONULL 0
`define IMU_CMD_RESTORE  1
`define IMU_CMD_DAC      2
`define IMU_CMD_FLASH    3
`define IMU_CMD_PREC     4
`define IMU_CMD_SWRESET  7
`define IMU_MISC_LINCOMP 7
`define IMU_SMPL_BASE    7
`define IMU_SLP_INF      8
`define IMU_LOW_POWER_MIN 8'h0A
`define IMU_M_GYRO 16'h1FFF
`define IMU_M_ACCL 16'h0FFF
`define IMU_M_HIF  16'h3FFF
`define IMU_M_SIF  16'h0FFF
`define IMU_M_MISC 16'h0FC7
`define IMU_M_SMPL 16'h00FF
`define IMU_M_FILT 16'h0707
`define IMU_M_SLP  16'h01FF
`define IMU_M_DAC  16'h0FFF
`define IMU_FILT_MAX_LOG 3'h4
`define IMU_SIF_SHIFT    11
`define IMU_GLIN_SHIFT   8
`define IMU_EMA_SHIFT    6

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define IMU_RST_ZERO 16'h0000
`define IMU_RST_SIF  16'h0800
`define IMU_RST_MISC 16'h0006
`define IMU_RST_SMPL 16'h0001
`define IMU_RST_FILT 16'h0402

`endif

// file: testbench/imu_cal_ctrl_checker.sv
// port checker for the calibration and control block
// sees only the top ports; bound at the foot
`timescale 1ns/10ps
module imu_chk #(parameter [31:0] P_FLASH_CYC = 30, P_PREC_CYC = 200) (
  input wire        mclk, rstn, spi_cs_n, spi_dout_oe, low_power, sleeping,
  input wire        flash_busy, offline, sample_tick,
  input wire [11:0] dac_data
);
  reg [31:0] nf, no;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // busy cycle counters
  always @(posedge mclk or negedge rstn)
    if (!rstn) begin
      nf <= 32'h0;
      no <= 32'h0;
    end else begin
      nf <= flash_busy ? nf + 32'h1 : 32'h0;
      no <= offline ? no + 32'h1 : 32'h0;
    end
  chk_oe_select: assert property ($fell(spi_cs_n) |-> ##[2:5] spi_dout_oe)
    else $error("dout enable late");
  chk_oe_idle: assert property (spi_cs_n [*5] |-> !spi_dout_oe)
    else $error("dout enable while idle");
  chk_tick_gap: assert property (sample_tick |=> !sample_tick [*3])
    else $error("sample ticks too close");
  chk_flash_len: assert property ($fell(flash_busy) |-> nf == P_FLASH_CYC)
    else $error("flash commit length");
  chk_null_len: assert property ($fell(offline) |-> no == P_PREC_CYC)
    else $error("offline length");
  chk_null_commit: assert property ($fell(offline) |-> ##[0:2] flash_busy)
    else $error("no commit after null");
  chk_sleep_wake: assert property (sleeping && $fell(spi_cs_n) |-> ##[1:6] !sleeping)
    else $error("no wake on select");
  chk_ctrl_write: assert property ($changed({dac_data, low_power}) |-> !$past(spi_cs_n, 5))
    else $error("control change without frame");
endmodule // imu_chk
bind imu_cal_ctrl imu_chk #(.P_FLASH_CYC(P_FLASH_CYC), .P_PREC_CYC(P_PREC_CYC)) i_imu_chk (
  .mclk, .rstn, .spi_cs_n, .spi_dout_oe, .low_power, .sleeping, .flash_busy, .offline,
  .sample_tick, .dac_data);

// file: testbench/imu_host.sv
// serial host model: sclk idles high, din set on fall, dout taken on rise
// assumes mclk at 125 MHz; sclk half period 8 mclk
`timescale 1ns/10ps
module imu_host (
  input  wire mclk,  // clock
  output reg  sclk,  // serial clock
  output reg  cs_n,  // chip select
  output reg  din,   // data to device
  input  wire dout   // data from device
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b1;
  end
  task sel(input v);
    begin
      @(posedge mclk);
      cs_n <= v;
      repeat (6) @(posedge mclk);
    end
  endtask
  task xfer(input [15:0] w, output [15:0] r);
    integer i;
    begin
      for (i = 15; i >= 0; i = i - 1) begin
        @(posedge mclk);
        sclk <= 1'b0;
        din <= w[i];
        repeat (8) @(posedge mclk);
        sclk <= 1'b1;
        r[i] = dout;
        repeat (7) @(posedge mclk);
      end
      din <= ~din;
      repeat (8) @(posedge mclk);
    end
  endtask
endmodule // imu_host

// file: testbench/tb.sv
// self-checking bench for the calibration and control block
// shortened times; gyro x raw from one driven value, other axes random
`timescale 1ns/10ps
module tb;
  reg        mclk, rstn, gv;
  reg [13:0] graw;
  reg [127:0] oraw;
  reg [11:0] aux;
  wire       sclk, cs_n, din, sdo, oe, lp, slp, fb, off, tick;
  // released line pulled up
  wire       dout = oe ? sdo : 1'b1;
  wire [11:0] dac;
  integer    miscompares = 0, checks = 0, seed = 32'hF5C5, cyc = 0, i, t, ts;
  reg [15:0] q [$];
  reg [15:0] rw, got, v, e;
  reg [7:0]  sp [0:3] = '{8'h0A, 8'h81, 8'h09, 8'h01};
  integer    per [0:3] = '{44, 40, 40, 8};
  imu_cal_ctrl #(.P_TB_SHORT_CYC(4), .P_TB_LONG_CYC(20), .P_SLEEP_CYC(50), .P_FLASH_CYC(30),
    .P_PREC_CYC(200)) i_imu_cal_ctrl (.mclk, .rstn, .spi_sclk(sclk), .spi_cs_n(cs_n),
    .spi_din(din), .spi_dout(sdo), .spi_dout_oe(oe), .gyro_x_raw(graw),
    .gyro_y_raw(oraw[13:0]), .gyro_z_raw(oraw[27:14]), .accel_x_raw(oraw[41:28]),
    .accel_y_raw(oraw[55:42]), .accel_z_raw(oraw[69:56]), .mag_x_raw(oraw[83:70]),
    .mag_y_raw(oraw[97:84]), .mag_z_raw(oraw[111:98]), .aux_adc_code(aux), .dac_data(dac),
    .low_power(lp), .sleeping(slp), .flash_busy(fb), .offline(off), .sample_tick(tick));
  imu_host i_imu_host (.mclk, .sclk, .cs_n, .din, .dout);
  task cmp(input [127:0] n, input [15:0] x, input [15:0] g);
    begin
      checks = checks + 1;
      if (g !== x) begin
        miscompares = miscompares + 1;
        $display("[FAIL] %0s expected %h seen %h", n, x, g);
      end
    end
  endtask
  task wb(input [6:0] a, input [7:0] d);
    i_imu_host.xfer({1'b1, a, d}, rw);
  endtask
  task rd(input [6:0] a, input [15:0] x);
    begin
      q.push_back(x);
      i_imu_host.xfer({1'b0, a, 8'h00}, rw);
      i_imu_host.xfer(16'h0000, got);
      gv <= 1'b1;
      @(posedge mclk);
      gv <= 1'b0;
    end
  endtask
  // burst of twelve words, last one is the aux result
  task brd(input [15:0] x);
    begin
      q.push_back(x);
      i_imu_host.xfer(16'h3E00, rw);
      for (t = 0; t < 12; t = t + 1)
        i_imu_host.xfer(16'h0000, got);
      gv <= 1'b1;
      @(posedge mclk);
      gv <= 1'b0;
      i_imu_host.sel(1'b1);
      i_imu_host.sel(1'b0);
    end
  endtask
  task idle;
    for (t = 0; t < 2000 && (fb || off || slp); t = t + 1) @(posedge mclk);
  endtask
  task print_verdict;
    begin
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  always @(posedge mclk) if (gv) cmp("register", q.pop_front(), got);
  always @(posedge slp) ts = cyc;
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      miscompares = miscompares + 1;
      print_verdict;
    end
  end
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    rstn = 1'b0; gv = 1'b0; graw = 14'h0000; aux = 12'h000;
    oraw = 128'h0;
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    oraw <= {$random(seed), $random(seed), $random(seed), $random(seed)};
    repeat (8) @(posedge mclk);
    i_imu_host.sel(1'b0);
    rd(7'h2D, 16'h0800);
    rd(7'h37, 16'h0001);
    rd(7'h1A, 16'h0000);
    rd(7'h3A, 16'h0000);
    for (i = 0; i < 4; i = i + 1) begin
      v = $random(seed);
      wb(7'h1A + 6 * i, v[7:0]);
      wb(7'h1B + 6 * i, v[15:8]);
      rd(7'h1A + 6 * i, v & (i == 0 ? 16'h1FFF : i == 2 ? 16'h3FFF : 16'h0FFF));
    end
    v = $random(seed);
    aux <= v[11:0];
    wb(7'h4A, v[7:0]);
    wb(7'h4B, v[15:8]);
    wb(7'h3E, 8'h04);
    cmp("dac", {4'h0, v[11:0]}, {4'h0, dac});
    brd({4'h0, v[11:0]});
    $display("test registers done");
    for (i = 0; i < 4; i = i + 1) begin
      wb(7'h36, sp[i]);
      cmp("low_power", {15'h0000, sp[i] >= 8'h0A}, {15'h0000, lp});
      repeat (2) @(posedge tick);
      t = cyc;
      @(posedge tick);
      cmp("period", per[i], cyc - t);
    end
    $display("test sample period done");
    wb(7'h3E, 8'h02);
    idle;
    rd(7'h20, 16'h0000);
    rd(7'h2C, 16'h0000);
    v = $random(seed);
    graw <= {{5{v[8]}}, v[8:0]};
    repeat (300) @(posedge mclk);
    e = (16'h0000 - ({{2{graw[13]}}, graw} << 2)) & 16'h1FFF;
    wb(7'h3E, 8'h01);
    idle;
    rd(7'h1A, e);
    repeat (300) @(posedge mclk);
    wb(7'h3E, 8'h10);
    idle;
    rd(7'h1A, e);
    wb(7'h1A, 8'h55);
    wb(7'h3E, 8'h80);
    idle;
    rd(7'h1A, e);
    v = $random(seed);
    wb(7'h34, 8'h86);
    wb(7'h35, v[15:8]);
    rd(7'h34, {4'h0, v[11:8], 8'h86});
    $display("test commands done");
    wb(7'h3A, 8'h02);
    i_imu_host.sel(1'b1);
    @(negedge slp);
    cmp("sleep_time", 16'd100, cyc - ts);
    i_imu_host.sel(1'b0);
    wb(7'h3B, 8'h01);
    i_imu_host.sel(1'b1);
    repeat (300) @(posedge mclk);
    cmp("sleeping", 16'h0001, {15'h0000, slp});
    i_imu_host.sel(1'b0);
    cmp("sleeping", 16'h0000, {15'h0000, slp});
    $display("test sleep done");
    print_verdict;
  end
endmodule // tb
